// [dv/msc_input_model.sv]
// Digital signal input source that drives the hold pin
module msc_input_model (
  // Requested level
  input  wire logic req,
  // Pin toward the device
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Off-grid delay: the pin never moves on a clock edge, like a real switch
  initial begin
    pin = 1'h0;
    forever begin
      @(req);
      pin <= #7 req;
    end
  end
endmodule : msc_input_model

// [dv/msc_stop_ctrl_tb.sv]
// Self-checking bench for the stop control block
module msc_stop_ctrl_tb
  import msc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, rst_n = 1'h0, par_wr = 1'h0, par_rd = 1'h0, pin_req = 1'h0;
  logic        fb_hold = 1'h0, fb_quick_stop = 1'h0, err_class1 = 1'h0, err_class2 = 1'h0;
  logic        hold_input_function = 1'h0, state_release = 1'h0, mode_vel_profile = 1'h1;
  logic        motor_start = 1'h0, motor_standstill = 1'h0, hold_pin;
  logic [15:0] par_addr = 16'h0000, quick_stop_current_limit = 16'h0123, torque_limit;
  logic [31:0] par_wdata = 32'h0000_0000, par_rdata, decel_rate;
  logic        par_ack, par_err, decel_active, ramp_linear, torque_ramp, resume_req;
  logic [3:0]  op_state;
  int          miscompares = 0, cmp_count = 0;
  // Write table: illegal values and addresses first, then the legal boundaries
  logic [15:0] wa [8] = '{16'h0616, 16'h0616, 16'h0624, 16'h0630, 16'h0630, 16'h0700,
                          16'h0616, 16'h0624};
  logic [31:0] wd [8] = '{32'h0000_00C7, 32'h002D_C6C1, 32'h0000_0000, 32'h0000_0007,
                          32'h0000_FFFE, 32'h0000_0001, 32'h0000_00C8, 32'h002D_C6C0};
  logic [7:0]  we = 8'h3F;

  always #12.5 clk = ~clk;

  msc_input_model u_msc_input_model (.req(pin_req), .pin(hold_pin));
  msc_stop_ctrl u_msc_stop_ctrl (
    .clk(clk), .rst_n(rst_n), .par_addr(par_addr), .par_wdata(par_wdata), .par_wr(par_wr),
    .par_rd(par_rd), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
    .fb_hold(fb_hold), .fb_quick_stop(fb_quick_stop), .err_class1(err_class1),
    .err_class2(err_class2), .hold_pin(hold_pin), .hold_input_function(hold_input_function),
    .state_release(state_release), .mode_vel_profile(mode_vel_profile),
    .motor_start(motor_start), .motor_standstill(motor_standstill),
    .quick_stop_current_limit(quick_stop_current_limit), .decel_active(decel_active),
    .decel_rate(decel_rate), .ramp_linear(ramp_linear), .torque_ramp(torque_ramp),
    .torque_limit(torque_limit), .resume_req(resume_req), .op_state(op_state));

  ////////////////////////////////////////////////////////////////////////////////
  task ck(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : ck

  task t(input int n);
    repeat (n) @(posedge clk);
  endtask : t

  // One parameter access; a read also compares the returned word
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e,
           input logic [31:0] r);
    t(1);
    par_addr  <= a;
    par_wdata <= d;
    par_wr    <= w;
    par_rd    <= ~w;
    t(1);
    par_wr <= 1'h0;
    par_rd <= 1'h0;
    @(negedge clk);
    ck(par_ack, 1'h1);
    ck(par_err, e);
    if (!w) ck(par_rdata, r);
  endtask : acc

  task cs(input logic d, input logic [31:0] r, input logic l, input logic [3:0] o);
    @(negedge clk);
    ck(decel_active, d);
    ck(decel_rate, r);
    ck(ramp_linear, l);
    ck(op_state, o);
  endtask : cs

  // Motor reaches rest, final state checked, then the stop state is left
  task land(input logic [3:0] o);
    t(1);
    motor_standstill <= 1'h1;
    t(1);
    cs(1'h0, 32'h0000_0000, 1'h0, o);
    ck(resume_req, 1'h0);
    t(1);
    motor_standstill <= 1'h0;
    state_release    <= 1'h1;
    t(1);
    state_release <= 1'h0;
    cs(1'h0, 32'h0000_0000, 1'h0, OPST_NORMAL);
  endtask : land

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    t(12);
    rst_n <= 1'h1;
    acc(1'h0, ADDR_PROFILE_DECEL, 32'h0000_0000, 1'h0, RST_PROFILE_DECEL);
    acc(1'h0, ADDR_QS_RAMP, 32'h0000_0000, 1'h0, RST_QS_RAMP);
    acc(1'h0, ADDR_QS_REACT, 32'h0000_0000, 1'h0, 32'h0000_0006);
    for (int i = 0; i < 8; i++) begin
      acc(1'h1, wa[i], wd[i], we[i], 32'h0000_0000);
    end
    acc(1'h0, ADDR_PROFILE_DECEL, 32'h0000_0000, 1'h0, 32'h0000_00C8);
    acc(1'h0, ADDR_QS_RAMP, 32'h0000_0000, 1'h0, 32'h002D_C6C0);
    acc(1'h0, ADDR_QS_REACT, 32'h0000_0000, 1'h0, 32'h0000_0006);
    // Fieldbus hold, withdrawn while still braking; new ramp not yet latched
    t(1);
    fb_hold <= 1'h1;
    t(1);
    cs(1'h1, RST_PROFILE_DECEL, 1'h0, OPST_NORMAL);
    t(1);
    fb_hold <= 1'h0;
    t(2);
    cs(1'h1, RST_PROFILE_DECEL, 1'h0, OPST_NORMAL);
    t(1);
    motor_standstill <= 1'h1;
    t(1);
    @(negedge clk);
    ck(resume_req, 1'h1);
    ck(decel_active, 1'h0);
    t(1);
    motor_standstill <= 1'h0;
    @(negedge clk);
    ck(resume_req, 1'h0);
    // Pin hold only once the input has the hold function
    t(1);
    pin_req <= 1'h1;
    t(8);
    cs(1'h0, 32'h0000_0000, 1'h0, OPST_NORMAL);
    t(1);
    hold_input_function <= 1'h1;
    t(6);
    cs(1'h1, RST_PROFILE_DECEL, 1'h0, OPST_NORMAL);
    t(1);
    pin_req          <= 1'h0;
    motor_standstill <= 1'h1;
    t(8);
    cs(1'h0, 32'h0000_0000, 1'h0, OPST_NORMAL);
    t(1);
    motor_standstill    <= 1'h0;
    hold_input_function <= 1'h0;
    fb_quick_stop       <= 1'h1;
    t(1);
    fb_quick_stop <= 1'h0;
    cs(1'h1, RST_QS_RAMP, 1'h1, OPST_QSA);
    acc(1'h1, ADDR_QS_REACT, 32'h0000_FFFF, 1'h0, 32'h0000_0000);
    acc(1'h0, ADDR_QS_REACT, 32'h0000_0000, 1'h0, 32'hFFFF_FFFF);
    land(OPST_FAULT);
    // A new start latches the new ramps
    t(1);
    motor_start <= 1'h1;
    t(1);
    motor_start <= 1'h0;
    err_class1  <= 1'h1;
    t(1);
    err_class1 <= 1'h0;
    cs(1'h1, 32'h002D_C6C0, 1'h1, OPST_QSA);
    land(OPST_FAULT);
    acc(1'h1, ADDR_QS_REACT, 32'h0000_0006, 1'h0, 32'h0000_0000);
    t(1);
    mode_vel_profile <= 1'h0;
    err_class2       <= 1'h1;
    t(1);
    err_class2 <= 1'h0;
    cs(1'h1, 32'h0000_0000, 1'h1, OPST_QSA);
    ck(torque_ramp, 1'h1);
    ck(torque_limit, 16'h0123);
    land(OPST_QSA);
    // Emergency stop overrides a running hold
    t(1);
    mode_vel_profile <= 1'h1;
    fb_hold          <= 1'h1;
    t(1);
    cs(1'h1, 32'h0000_00C8, 1'h0, OPST_NORMAL);
    t(1);
    fb_quick_stop <= 1'h1;
    t(1);
    fb_quick_stop <= 1'h0;
    cs(1'h1, 32'h002D_C6C0, 1'h1, OPST_QSA);
    t(1);
    fb_hold <= 1'h0;
    land(OPST_QSA);
    // A legal code between the two named ones also ends in Quick Stop Active
    acc(1'h1, ADDR_QS_REACT, 32'h0000_0003, 1'h0, 32'h0000_0000);
    t(1);
    fb_quick_stop <= 1'h1;
    t(1);
    fb_quick_stop <= 1'h0;
    cs(1'h1, 32'h002D_C6C0, 1'h1, OPST_QSA);
    land(OPST_QSA);
    // Reset in mid-run restores every parameter and the latched ramps
    t(1);
    rst_n <= 1'h0;
    t(4);
    rst_n <= 1'h1;
    acc(1'h0, ADDR_PROFILE_DECEL, 32'h0000_0000, 1'h0, RST_PROFILE_DECEL);
    acc(1'h0, ADDR_QS_RAMP, 32'h0000_0000, 1'h0, RST_QS_RAMP);
    acc(1'h0, ADDR_QS_REACT, 32'h0000_0000, 1'h0, 32'h0000_0006);
    t(1);
    fb_quick_stop <= 1'h1;
    t(1);
    fb_quick_stop <= 1'h0;
    cs(1'h1, RST_QS_RAMP, 1'h1, OPST_QSA);
    land(OPST_QSA);
    tally_and_finish();
  end
endmodule : msc_stop_ctrl_tb

// [inc/msc_pkg.sv]
// Shared constants and types for the motion stop control block
package msc_pkg;

  // Parameter addresses
  localparam logic [15:0] ADDR_PROFILE_DECEL = 16'h0616;
  localparam logic [15:0] ADDR_QS_RAMP       = 16'h0624;
  localparam logic [15:0] ADDR_QS_REACT      = 16'h0630;

  // Reset values
  localparam logic [31:0] RST_PROFILE_DECEL = 32'h0000_02EE;
  localparam logic [31:0] RST_QS_RAMP       = 32'h0000_1770;
  localparam logic [15:0] RST_QS_REACT      = 16'h0006;

  // Ramp limits in RPM/s
  localparam logic [31:0] RAMP_MIN = 32'h0000_00C8;
  localparam logic [31:0] RAMP_MAX = 32'h002D_C6C0;

  // Reaction codes, signed 16 bit
  localparam logic signed [15:0] REACT_FAULT = 16'shFFFF;
  localparam logic signed [15:0] REACT_QSA   = 16'sh0006;

  // Operating state codes reported on op_state
  localparam logic [3:0] OPST_NORMAL = 4'h0;
  localparam logic [3:0] OPST_QSA    = 4'h7;
  localparam logic [3:0] OPST_FAULT  = 4'h9;

  typedef enum logic [6:0] {
    MSC_RUN        = 7'b000_0001,
    MSC_HOLD_DECEL = 7'b000_0010,
    MSC_HOLD_STILL = 7'b000_0100,
    MSC_QS_DECEL   = 7'b000_1000,
    MSC_QS_ACTIVE  = 7'b001_0000,
    MSC_FAULT      = 7'b010_0000,
    MSC_TORQUE_QS  = 7'b100_0000
  } msc_state_t;

endpackage : msc_pkg

// [verilog/msc_stop_ctrl.sv]
// Hold and emergency stop control with its ramp parameters
module msc_stop_ctrl
  import msc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Parameter access from the fieldbus
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  output logic      [31:0] par_rdata,
  output logic             par_ack,
  output logic             par_err,
  // Stop requests
  input  wire logic        fb_hold,
  input  wire logic        fb_quick_stop,
  input  wire logic        err_class1,
  input  wire logic        err_class2,
  input  wire logic        hold_pin,
  input  wire logic        hold_input_function,
  input  wire logic        state_release,
  // Motion engine status
  input  wire logic        mode_vel_profile,
  input  wire logic        motor_start,
  input  wire logic        motor_standstill,
  input  wire logic [15:0] quick_stop_current_limit,
  // Stop commands to the motion engine
  output logic             decel_active,
  output logic      [31:0] decel_rate,
  output logic             ramp_linear,
  output logic             torque_ramp,
  output logic      [15:0] torque_limit,
  output logic             resume_req,
  output logic      [3:0]  op_state
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    msc_state_t  st;
    logic [31:0] profile_decel;
    logic [31:0] qs_ramp;
    logic [15:0] qs_react;
    logic [31:0] act_profile;
    logic [31:0] act_qs;
    logic        decel_active;
    logic [31:0] decel_rate;
    logic        ramp_linear;
    logic        torque_ramp;
    logic [15:0] torque_limit;
    logic        resume_req;
    logic [3:0]  op_state;
    logic [31:0] par_rdata;
    logic        par_ack;
    logic        par_err;
  } msc_regs_t;

  msc_regs_t q;
  msc_regs_t next_q;
  logic      pin_level;
  logic      hold_req;
  logic      qs_req;
  logic      ramp_ok;
  logic      react_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  msc_sync u_hold_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (hold_pin),
    .level (pin_level)
  );

  assign hold_req = fb_hold | (hold_input_function & pin_level);
  assign qs_req   = fb_quick_stop | err_class1 | err_class2;
  assign ramp_ok  = (par_wdata >= RAMP_MIN) && (par_wdata <= RAMP_MAX);
  assign react_ok = ($signed(par_wdata[15:0]) >= REACT_FAULT)
                 && ($signed(par_wdata[15:0]) <= REACT_QSA);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_q            = q;
    next_q.par_ack    = 1'b0;
    next_q.par_err    = 1'b0;
    next_q.resume_req = 1'b0;

    // Parameter writes; out of range values are refused and the old value kept
    if (par_wr) begin
      next_q.par_ack = 1'b1;
      case (par_addr)
        ADDR_PROFILE_DECEL: begin
          if (ramp_ok) next_q.profile_decel = par_wdata;
          else         next_q.par_err = 1'b1;
        end
        ADDR_QS_RAMP: begin
          if (ramp_ok) next_q.qs_ramp = par_wdata;
          else         next_q.par_err = 1'b1;
        end
        ADDR_QS_REACT: begin
          if (react_ok) next_q.qs_react = par_wdata[15:0];
          else          next_q.par_err = 1'b1;
        end
        default: next_q.par_err = 1'b1;
      endcase
    end else if (par_rd) begin
      next_q.par_ack = 1'b1;
      case (par_addr)
        ADDR_PROFILE_DECEL: next_q.par_rdata = q.profile_decel;
        ADDR_QS_RAMP:       next_q.par_rdata = q.qs_ramp;
        ADDR_QS_REACT:      next_q.par_rdata = {{16{q.qs_react[15]}}, q.qs_react};
        default: begin
          next_q.par_rdata = '0;
          next_q.par_err   = 1'b1;
        end
      endcase
    end

    // Ramps are copied only when a new movement starts, never mid-move
    if (motor_start && q.st == MSC_RUN) begin
      next_q.act_profile = q.profile_decel;
      next_q.act_qs      = q.qs_ramp;
    end

    // Stop sequencing
    case (q.st)
      MSC_RUN: begin
        if (qs_req) next_q.st = mode_vel_profile ? MSC_QS_DECEL : MSC_TORQUE_QS;
        else if (hold_req) next_q.st = MSC_HOLD_DECEL;
      end
      MSC_HOLD_DECEL: begin
        // Emergency stop wins over a hold
        if (qs_req) next_q.st = mode_vel_profile ? MSC_QS_DECEL : MSC_TORQUE_QS;
        else if (motor_standstill) begin
          // A hold dropped while braking still waits for standstill
          if (hold_req) next_q.st = MSC_HOLD_STILL;
          else begin
            next_q.st         = MSC_RUN;
            next_q.resume_req = 1'b1;
          end
        end
      end
      MSC_HOLD_STILL: begin
        if (qs_req) next_q.st = mode_vel_profile ? MSC_QS_DECEL : MSC_TORQUE_QS;
        else if (!hold_req) begin
          next_q.st         = MSC_RUN;
          next_q.resume_req = 1'b1;
        end
      end
      MSC_QS_DECEL, MSC_TORQUE_QS: begin
        // The live reaction code decides, so a late write still counts
        if (motor_standstill) begin
          if ($signed(q.qs_react) == REACT_FAULT) next_q.st = MSC_FAULT;
          else next_q.st = MSC_QS_ACTIVE;
        end
      end
      MSC_QS_ACTIVE, MSC_FAULT: begin
        if (state_release && !qs_req) next_q.st = MSC_RUN;
      end
      default: next_q.st = MSC_RUN;
    endcase

    // Outputs follow the next state so they line up with the state register
    next_q.decel_active = 1'b0;
    next_q.decel_rate   = '0;
    next_q.ramp_linear  = 1'b0;
    next_q.torque_ramp  = 1'b0;
    next_q.torque_limit = '0;
    next_q.op_state     = OPST_NORMAL;
    case (next_q.st)
      MSC_HOLD_DECEL, MSC_HOLD_STILL: begin
        next_q.decel_active = 1'b1;
        next_q.decel_rate   = next_q.act_profile;
      end
      MSC_QS_DECEL: begin
        next_q.decel_active = 1'b1;
        next_q.decel_rate   = next_q.act_qs;
        next_q.ramp_linear  = 1'b1;
        next_q.op_state     = OPST_QSA;
      end
      MSC_TORQUE_QS: begin
        next_q.decel_active = 1'b1;
        next_q.torque_ramp  = 1'b1;
        next_q.torque_limit = quick_stop_current_limit;
        next_q.ramp_linear  = 1'b1;
        next_q.op_state     = OPST_QSA;
      end
      MSC_QS_ACTIVE: next_q.op_state = OPST_QSA;
      MSC_FAULT:     next_q.op_state = OPST_FAULT;
      default: next_q.op_state = OPST_NORMAL;
    endcase

    if (!rst_n) begin
      next_q               = '0;
      next_q.st            = MSC_RUN;
      next_q.profile_decel = RST_PROFILE_DECEL;
      next_q.qs_ramp       = RST_QS_RAMP;
      next_q.qs_react      = RST_QS_REACT;
      next_q.act_profile   = RST_PROFILE_DECEL;
      next_q.act_qs        = RST_QS_RAMP;
      next_q.op_state      = OPST_NORMAL;
    end
  end

  always_ff @(posedge clk) begin
    q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign par_rdata    = q.par_rdata;
  assign par_ack      = q.par_ack;
  assign par_err      = q.par_err;
  assign decel_active = q.decel_active;
  assign decel_rate   = q.decel_rate;
  assign ramp_linear  = q.ramp_linear;
  assign torque_ramp  = q.torque_ramp;
  assign torque_limit = q.torque_limit;
  assign resume_req   = q.resume_req;
  assign op_state     = q.op_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_react_range: assert property (@(posedge clk) disable iff (!rst_n)
    ($signed(q.qs_react) >= REACT_FAULT) && ($signed(q.qs_react) <= REACT_QSA))
    else $error("reaction code out of range");

  a_qs_start: assert property (@(posedge clk) disable iff (!rst_n)
    (qs_req && (q.st == MSC_RUN || q.st == MSC_HOLD_DECEL || q.st == MSC_HOLD_STILL))
    |=> (q.st == MSC_QS_DECEL || q.st == MSC_TORQUE_QS) && q.decel_active)
    else $error("emergency stop not started");

  a_fault_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_QS_DECEL && motor_standstill && $signed(q.qs_react) == REACT_FAULT)
    |=> q.op_state == OPST_FAULT)
    else $error("fault state not entered");

  a_hold_ramp: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_HOLD_DECEL) |-> (q.decel_rate == q.act_profile) && !q.ramp_linear)
    else $error("hold uses wrong ramp");

  a_hold_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_RUN && !fb_hold && !hold_input_function && !qs_req) |=> q.st == MSC_RUN)
    else $error("unassigned input caused a hold");

  a_resume_still: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_HOLD_DECEL && !motor_standstill) |=> !q.resume_req)
    else $error("resumed before standstill");

  a_ramp_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_RUN && !motor_start) |=> q.act_qs == $past(q.act_qs))
    else $error("emergency ramp changed mid-move");

  a_torque_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_RUN && qs_req && !mode_vel_profile) |=> q.torque_ramp && q.decel_rate == '0)
    else $error("torque ramp not chosen");

  a_qs_linear: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_QS_DECEL) |-> q.ramp_linear && q.decel_rate == q.act_qs)
    else $error("emergency ramp not linear");

  a_no_resume_qs: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_QS_DECEL || q.st == MSC_QS_ACTIVE || q.st == MSC_FAULT) |-> !q.resume_req)
    else $error("resumed during emergency stop");

  a_hold_resume: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_HOLD_STILL && !hold_req && !qs_req) |=> q.st == MSC_RUN && q.resume_req)
    else $error("hold not resumed");

  a_hold_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == MSC_HOLD_DECEL && !motor_standstill && !qs_req)
    |=> q.st == MSC_HOLD_DECEL && q.decel_active)
    else $error("hold braking ended early");

  a_qs_landing: assert property (@(posedge clk) disable iff (!rst_n)
    ((q.st == MSC_QS_DECEL || q.st == MSC_TORQUE_QS) && motor_standstill
      && $signed(q.qs_react) != REACT_FAULT)
    |=> q.st == MSC_QS_ACTIVE && q.op_state == OPST_QSA && !q.decel_active)
    else $error("quick stop active not entered");

endmodule : msc_stop_ctrl

// [verilog/msc_sync.sv]
// Three-stage input synchroniser with agreement filter
module msc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous input and clean level
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } msc_sync_t;

  msc_sync_t q;
  msc_sync_t next_q;

  always_comb begin
    next_q    = q;
    next_q.s1 = pin;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    // Only the second and third stages vote; the first may be metastable
    if (q.s2 == q.s3) begin
      next_q.lvl = q.s3;
    end
    if (!rst_n) begin
      next_q = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= next_q;
  end

  assign level = q.lvl;

endmodule : msc_sync
